// ===== include/cff_pkg.sv
// Constants for the CAN filter and FIFO configuration block
package cff_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] CFF_OFS_FLT_BANK = 8'h00;
  localparam logic [7:0] CFF_OFS_BASE     = 8'h04;
  localparam logic [7:0] CFF_OFS_MATCH    = 8'h40;
  localparam logic [7:0] CFF_OFS_FIFO     = 8'h80;
  localparam logic [7:0] CFF_OFS_MATCH_HI = 8'h4c;
  localparam logic [7:0] CFF_OFS_FIFO_HI  = 8'hbc;

  // Sizes
  localparam int CFF_NUM_FILT   = 4;
  localparam int CFF_NUM_FIFO   = 16;
  localparam int CFF_NUM_MASK   = 4;
  localparam logic [3:0] CFF_FIRST_FILT = 4'hc;

  // Filter bank byte layout (one byte per filter)
  localparam int CFF_FLT_ON_BIT   = 7;
  localparam int CFF_FLT_MASK_LSB = 5;
  localparam int CFF_FLT_DEST_LSB = 0;

  // Identifier match register layout
  localparam int CFF_SID_LSB      = 21;
  localparam int CFF_XONLY_BIT    = 19;
  localparam int CFF_EID_MSB      = 17;
  localparam logic [31:0] CFF_MATCH_WMASK = 32'hffeb_ffff;
  localparam logic [31:0] CFF_BASE_WMASK  = 32'hffff_fffc;

  // FIFO control layout
  localparam int CFF_SIZE_LSB = 16;
  localparam int CFF_CLR_BIT  = 14;
  localparam int CFF_ADV_BIT  = 13;
  localparam int CFF_PAY_BIT  = 12;
  localparam int CFF_DIR_BIT  = 7;
  localparam int CFF_ABT_BIT  = 6;
  localparam int CFF_ARB_BIT  = 5;
  localparam int CFF_BERR_BIT = 4;
  localparam int CFF_REQ_BIT  = 3;
  localparam int CFF_RTR_BIT  = 2;
  localparam int CFF_PRI_LSB  = 0;

  // Mode and storage figures
  localparam logic [2:0]  CFF_MODE_CONFIG   = 3'h4;
  localparam logic [4:0]  CFF_SIZE_MAX      = 5'h0f;
  localparam logic [31:0] CFF_FULL_MSG_BYTES = 32'h0000_0010;
  localparam logic [31:0] CFF_PAYLOAD_BYTES  = 32'h0000_0008;

  // Reset values
  localparam logic [31:0] CFF_RST_WORD = 32'h0000_0000;
  localparam logic [7:0]  CFF_RST_BYTE = 8'h00;

endpackage

// ===== verilog/cff_filter_fifo_cfg.sv
// CAN acceptance filter and FIFO configuration registers with match logic
// How it works
// - Each filter has an on bit; only enabled filters join matching.
// - Two-bit mask choice picks acceptance mask 0 to 3.
// - Five-bit destination picks FIFO 0 to 15; codes 16 and up reserved.
// - Standard identifier bits must equal stored bits where the mask selects.
// - Frame-format bit: set matches extended frames only, clear standard only.
// - Extended identifier bits must equal stored bits where the mask selects; bits 20 and 18 read zero.
// - Match register writes land only while its filter is off.
// - Base address locates FIFO 0; each next FIFO follows the previous one.
// - Base address bits 1:0 always read zero.
// - Base address is writable only in configuration mode (100).
// - Depth field gives depth of field plus one; 16 and up reserved.
// - Clear request resets the FIFO, then hardware drops the bit; software polls.
// - Transmit FIFO: advance bit moves head by one message.
// - Receive FIFO: advance bit moves tail by one message.
// - Payload-only store keeps data bytes only, receive FIFOs only.
// - Depth field and payload-only bit change only in configuration mode.
// - Aborted flag updates on message completion or abort and on FIFO reset.
// - Arbitration-lost and bus-error flags clear on control read or reset.
// - Direction bit: 1 transmit FIFO, 0 receive FIFO.
// - Software sets send request; hardware clears when sent; software clear aborts.
// - Two-bit send priority ranks FIFOs, 11 highest, 00 lowest.
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ns
module cff_filter_fifo_cfg
  import cff_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // Module mode from the module control register
  input  wire logic [2:0]            operating_mode_field,
  // Acceptance masks: [28:18] standard, [17:0] extended
  input  wire logic [3:0][28:0]      acc_mask,
  // Received identifier from the protocol engine
  input  wire logic                  rx_id_valid,
  input  wire logic                  rx_is_extended,
  input  wire logic [10:0]           rx_sid,
  input  wire logic [17:0]           rx_eid,
  // Match result
  output logic                       match_hit,
  output logic      [3:0]            match_fifo,
  output logic      [3:0]            match_filter,
  output logic                       match_payload_only,
  // Engine events for the FIFO on eng_fifo
  input  wire logic [3:0]            eng_fifo,
  input  wire logic                  eng_done,
  input  wire logic                  eng_aborted,
  input  wire logic                  eng_arb_lost,
  input  wire logic                  eng_bus_err,
  input  wire logic                  eng_queue_sent,
  input  wire logic                  eng_remote_rx,
  // Buffer view of the FIFO on eng_fifo
  output logic      [31:0]           fifo_addr,
  output logic      [3:0]            fifo_ptr,
  output logic      [4:0]            fifo_depth,
  // Transmit selection and control pulses
  output logic                       tx_pick_valid,
  output logic      [3:0]            tx_pick_fifo,
  output logic                       abort_req,
  output logic      [3:0]            abort_fifo,
  output logic      [15:0]           fifo_clear_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Bytes taken by one slot of a FIFO
  function automatic logic [31:0] slot_bytes(input logic pay, input logic dir);
    slot_bytes = (pay && !dir) ? CFF_PAYLOAD_BYTES : CFF_FULL_MSG_BYTES;
  endfunction

  // Index within a register group
  function automatic logic [3:0] word_index(input logic [7:0] a);
    word_index = a[5:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [31:0] bank_q;
  logic [31:0] match_q [CFF_NUM_FILT];
  logic [31:0] base_q;
  logic [4:0]  size_q  [CFF_NUM_FIFO];
  logic        pay_q   [CFF_NUM_FIFO];
  logic        dir_q   [CFF_NUM_FIFO];
  logic        req_q   [CFF_NUM_FIFO];
  logic        rtr_q   [CFF_NUM_FIFO];
  logic [1:0]  pri_q   [CFF_NUM_FIFO];
  logic        abt_q   [CFF_NUM_FIFO];
  logic        arb_q   [CFF_NUM_FIFO];
  logic        berr_q  [CFF_NUM_FIFO];
  logic        clr_q   [CFF_NUM_FIFO];
  logic        adv_q   [CFF_NUM_FIFO];
  logic [3:0]  ptr_q   [CFF_NUM_FIFO];
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire       cfg_mode  = (operating_mode_field == CFF_MODE_CONFIG);
  wire       sel_bank  = (reg_addr == CFF_OFS_FLT_BANK);
  wire       sel_base  = (reg_addr == CFF_OFS_BASE);
  wire       sel_match = (reg_addr >= CFF_OFS_MATCH) && (reg_addr <= CFF_OFS_MATCH_HI)
                         && (reg_addr[1:0] == 2'b00);
  wire       sel_fifo  = (reg_addr >= CFF_OFS_FIFO) && (reg_addr <= CFF_OFS_FIFO_HI)
                         && (reg_addr[1:0] == 2'b00);
  wire [3:0] idx       = word_index(reg_addr);
  wire [1:0] midx      = idx[1:0];
  wire       wr_fifo   = reg_wr && sel_fifo;
  wire       rd_fifo   = reg_rd && sel_fifo;

  // Enable bit of the filter whose match register is addressed
  wire       match_flt_on = bank_q[{midx, 3'd7}];
  wire       wr_match     = reg_wr && sel_match && !match_flt_on;

  ////////////////////////////////////////////////////////////////////////////
  // Filter bank and match registers

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      bank_q <= CFF_RST_WORD;
    else if (reg_wr && sel_bank)
      bank_q <= reg_wdata;
  end

  // Match registers reset to zero; contents are undefined to software
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int k = 0; k < CFF_NUM_FILT; k++)
        match_q[k] <= CFF_RST_WORD;
    end
    else if (wr_match)
      match_q[midx] <= reg_wdata & CFF_MATCH_WMASK;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      base_q <= CFF_RST_WORD;
    else if (reg_wr && sel_base && cfg_mode)
      base_q <= reg_wdata & CFF_BASE_WMASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO control registers

  // Abort when software drops a set send request on a transmit FIFO
  wire abort_now = wr_fifo && dir_q[idx] && req_q[idx] && !reg_wdata[CFF_REQ_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < CFF_NUM_FIFO; i++)
      begin
        size_q[i] <= 5'h00;
        pay_q[i]  <= 1'b0;
        dir_q[i]  <= 1'b0;
        req_q[i]  <= 1'b0;
        rtr_q[i]  <= 1'b0;
        pri_q[i]  <= 2'b00;
        abt_q[i]  <= 1'b0;
        arb_q[i]  <= 1'b0;
        berr_q[i] <= 1'b0;
        clr_q[i]  <= 1'b0;
        adv_q[i]  <= 1'b0;
        ptr_q[i]  <= 4'h0;
      end
    end
    else
    begin
      for (int i = 0; i < CFF_NUM_FIFO; i++)
      begin
        // Pending clear request: reset pointer and status, then drop the bit
        if (clr_q[i])
        begin
          clr_q[i]  <= 1'b0;
          ptr_q[i]  <= 4'h0;
          adv_q[i]  <= 1'b0;
          req_q[i]  <= 1'b0;
          abt_q[i]  <= 1'b0;
          arb_q[i]  <= 1'b0;
          berr_q[i] <= 1'b0;
        end
        else
        begin
          // One slot per set, wrapping at the configured depth
          if (adv_q[i])
          begin
            adv_q[i] <= 1'b0;
            ptr_q[i] <= (ptr_q[i] == size_q[i][3:0]) ? 4'h0 : ptr_q[i] + 4'h1;
          end
          // Read clears the transmit outcome flags; a new event wins
          if (rd_fifo && idx == i[3:0])
          begin
            arb_q[i]  <= 1'b0;
            berr_q[i] <= 1'b0;
          end
          if (eng_fifo == i[3:0])
          begin
            if (eng_done)
              abt_q[i] <= eng_aborted;
            if (eng_arb_lost)
              arb_q[i] <= 1'b1;
            if (eng_bus_err)
              berr_q[i] <= 1'b1;
            if (eng_queue_sent)
              req_q[i] <= 1'b0;
            if (eng_remote_rx && rtr_q[i] && dir_q[i])
              req_q[i] <= 1'b1;
          end
          if (wr_fifo && idx == i[3:0])
          begin
            dir_q[i] <= reg_wdata[CFF_DIR_BIT];
            rtr_q[i] <= reg_wdata[CFF_RTR_BIT];
            pri_q[i] <= reg_wdata[CFF_PRI_LSB +: 2];
            if (dir_q[i])
              req_q[i] <= reg_wdata[CFF_REQ_BIT];
            if (cfg_mode)
            begin
              size_q[i] <= reg_wdata[CFF_SIZE_LSB +: 5];
              pay_q[i]  <= reg_wdata[CFF_PAY_BIT];
            end
            if (reg_wdata[CFF_CLR_BIT])
              clr_q[i] <= 1'b1;
            if (reg_wdata[CFF_ADV_BIT])
              adv_q[i] <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO placement in RAM

  // Reserved depth codes are treated as the largest legal depth for placement and fifo_depth
  logic [31:0] start_addr [CFF_NUM_FIFO];
  always_comb
  begin
    logic [31:0] acc;
    logic [4:0]  sz;
    acc = base_q;
    sz  = 5'h00;
    for (int i = 0; i < CFF_NUM_FIFO; i++)
    begin
      start_addr[i] = acc;
      sz = (size_q[i] > CFF_SIZE_MAX) ? CFF_SIZE_MAX : size_q[i];
      acc = acc + ({27'h0, sz} + 32'h1) * slot_bytes(pay_q[i], dir_q[i]);
    end
  end

  wire [4:0] eng_size = (size_q[eng_fifo] > CFF_SIZE_MAX) ? CFF_SIZE_MAX : size_q[eng_fifo];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fifo_addr  <= CFF_RST_WORD;
      fifo_ptr   <= 4'h0;
      fifo_depth <= 5'h01;
    end
    else
    begin
      fifo_addr  <= start_addr[eng_fifo];
      fifo_ptr   <= ptr_q[eng_fifo];
      fifo_depth <= eng_size + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance matching

  logic       hit_d;
  logic [3:0] hit_fifo_d;
  logic [3:0] hit_flt_d;
  always_comb
  begin
    logic [7:0]  fb;
    logic [28:0] m;
    logic        ok;
    fb         = 8'h00;
    m          = 29'h0;
    ok         = 1'b0;
    hit_d      = 1'b0;
    hit_fifo_d = 4'h0;
    hit_flt_d  = 4'h0;
    // Highest filter first so the lowest-numbered match wins
    for (int k = CFF_NUM_FILT - 1; k >= 0; k--)
    begin
      fb = bank_q[k*8 +: 8];
      m  = acc_mask[fb[CFF_FLT_MASK_LSB +: 2]];
      ok = fb[CFF_FLT_ON_BIT];
      ok = ok && (match_q[k][CFF_XONLY_BIT] == rx_is_extended);
      ok = ok && (((rx_sid ^ match_q[k][CFF_SID_LSB +: 11]) & m[28:18]) == 11'h000);
      if (rx_is_extended)
        ok = ok && (((rx_eid ^ match_q[k][CFF_EID_MSB:0]) & m[17:0]) == 18'h00000);
      ok = ok && !fb[CFF_FLT_DEST_LSB + 4];
      if (rx_id_valid && ok)
      begin
        hit_d      = 1'b1;
        hit_fifo_d = fb[CFF_FLT_DEST_LSB +: 4];
        hit_flt_d  = CFF_FIRST_FILT + 4'(k);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      match_hit          <= 1'b0;
      match_fifo         <= 4'h0;
      match_filter       <= 4'h0;
      match_payload_only <= 1'b0;
    end
    else
    begin
      match_hit          <= hit_d;
      match_fifo         <= hit_fifo_d;
      match_filter       <= hit_flt_d;
      match_payload_only <= pay_q[hit_fifo_d] && !dir_q[hit_fifo_d];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit selection

  logic       pick_d;
  logic [3:0] pick_fifo_d;
  always_comb
  begin
    logic [1:0] best;
    pick_d      = 1'b0;
    pick_fifo_d = 4'h0;
    best        = 2'b00;
    // Strictly higher priority replaces, so ties keep the lower index
    for (int i = 0; i < CFF_NUM_FIFO; i++)
    begin
      if (dir_q[i] && req_q[i] && !clr_q[i] && (!pick_d || pri_q[i] > best))
      begin
        pick_d      = 1'b1;
        pick_fifo_d = 4'(i);
        best        = pri_q[i];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_pick_valid <= 1'b0;
      tx_pick_fifo  <= 4'h0;
      abort_req     <= 1'b0;
      abort_fifo    <= 4'h0;
    end
    else
    begin
      tx_pick_valid <= pick_d;
      tx_pick_fifo  <= pick_fifo_d;
      abort_req     <= abort_now;
      abort_fifo    <= idx;
    end
  end

  always_comb
  begin
    for (int i = 0; i < CFF_NUM_FIFO; i++)
      fifo_clear_pulse[i] = clr_q[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [31:0] fifo_word;
  always_comb
  begin
    fifo_word = CFF_RST_WORD;
    fifo_word[CFF_SIZE_LSB +: 5] = size_q[idx];
    fifo_word[CFF_CLR_BIT]       = clr_q[idx];
    fifo_word[CFF_ADV_BIT]       = adv_q[idx];
    fifo_word[CFF_PAY_BIT]       = pay_q[idx];
    fifo_word[CFF_DIR_BIT]       = dir_q[idx];
    fifo_word[CFF_ABT_BIT]       = abt_q[idx];
    fifo_word[CFF_ARB_BIT]       = arb_q[idx];
    fifo_word[CFF_BERR_BIT]      = berr_q[idx];
    fifo_word[CFF_REQ_BIT]       = req_q[idx];
    fifo_word[CFF_RTR_BIT]       = rtr_q[idx];
    fifo_word[CFF_PRI_LSB +: 2]  = pri_q[idx];
  end

  wire [31:0] rd_mux = sel_bank  ? bank_q :
                       sel_base  ? base_q :
                       sel_match ? match_q[midx] :
                       sel_fifo  ? fifo_word : CFF_RST_WORD;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata_q <= CFF_RST_WORD;
    else if (reg_rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= CFF_RST_WORD;
  end

  assign reg_rdata = rdata_q;

endmodule

// ===== verif/cff_props.sv
// Port checker for the filter and FIFO configuration block
`timescale 1ns/1ns
module cff_props
  import cff_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Match and engine side
  input wire logic        rx_id_valid,
  input wire logic        match_hit,
  input wire logic [3:0]  match_filter,
  input wire logic        eng_arb_lost,
  input wire logic        eng_bus_err,
  input wire logic [4:0]  fifo_depth,
  input wire logic        abort_req,
  input wire logic [15:0] fifo_clear_pulse
);
  wire in_fifo = reg_addr >= CFF_OFS_FIFO && reg_addr <= CFF_OFS_FIFO_HI;
  wire in_mtch = reg_addr >= CFF_OFS_MATCH && reg_addr <= CFF_OFS_MATCH_HI;
  wire rd_fifo = reg_rd && in_fifo && reg_addr[1:0] == 2'h0;
  wire wr_fifo = reg_wr && in_fifo && reg_addr[1:0] == 2'h0;
  wire no_ev   = !eng_arb_lost && !eng_bus_err;
  logic [3:0] wr_idx_q;
  always_ff @(posedge clk_sys)
    wr_idx_q <= reg_addr[5:2];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  chk_clear_pulse: assert property ((wr_fifo && reg_wdata[CFF_CLR_BIT])
    |=> fifo_clear_pulse == (16'h1 << wr_idx_q)) else $error("clear pulse missing");
  chk_clear_single: assert property ((fifo_clear_pulse & $past(fifo_clear_pulse)) == 16'h0)
    else $error("clear pulse too long");
  chk_match_idle: assert property (!rx_id_valid |=> !match_hit)
    else $error("match without identifier");
  chk_match_range: assert property (match_hit |-> match_filter >= CFF_FIRST_FILT)
    else $error("winning filter out of range");
  chk_base_low: assert property ((reg_rd && reg_addr == CFF_OFS_BASE)
    |=> reg_rdata[1:0] == 2'h0) else $error("base low bits set");
  chk_match_zero: assert property ((reg_rd && in_mtch)
    |=> !reg_rdata[20] && !reg_rdata[18]) else $error("match spare bits set");
  chk_fifo_zero: assert property (rd_fifo |=> (reg_rdata & 32'hffe0_8f00) == 32'h0)
    else $error("control spare bits set");
  chk_flag_clear: assert property ((rd_fifo && no_ev) ##1 no_ev
    ##1 (rd_fifo && reg_addr == $past(reg_addr, 2)) |=> reg_rdata[5:4] == 2'h0)
    else $error("flags survive a read");
  chk_depth_span: assert property (fifo_depth >= 5'h01 && fifo_depth <= 5'h10)
    else $error("depth out of range");
  chk_abort_cause: assert property (abort_req |-> $past(reg_wr) && !$past(reg_wdata[3]))
    else $error("abort without clearing write");
endmodule
bind cff_filter_fifo_cfg cff_props i_props (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .rx_id_valid, .match_hit, .match_filter, .eng_arb_lost,
  .eng_bus_err, .fifo_depth, .abort_req, .fifo_clear_pulse);

// ===== verif/cff_engine_model.sv
// Behavioural protocol engine: identifiers and message events
`timescale 1ns/1ns
module cff_engine_model
(
  // Clock
  input  wire logic   clk_sys,
  // Received identifier
  output logic        rx_id_valid,
  output logic        rx_is_extended,
  output logic [10:0] rx_sid,
  output logic [17:0] rx_eid,
  // Events for one FIFO
  output logic [3:0]  eng_fifo,
  output logic        eng_done,
  output logic        eng_aborted,
  output logic        eng_arb_lost,
  output logic        eng_bus_err,
  output logic        eng_queue_sent,
  output logic        eng_remote_rx
);
  initial
  begin
    {rx_id_valid, rx_is_extended, rx_sid, rx_eid} = '0;
    eng_fifo = 4'h0;
    {eng_done, eng_aborted, eng_arb_lost, eng_bus_err, eng_queue_sent, eng_remote_rx} = '0;
  end
  // Released lines show the inverse, so a stale identifier never matches
  task automatic frame(input logic x, input logic [10:0] s, input logic [17:0] e);
    @(posedge clk_sys);
    rx_id_valid <= 1'b1;
    {rx_is_extended, rx_sid, rx_eid} <= {x, s, e};
    @(posedge clk_sys);
    rx_id_valid <= 1'b0;
    {rx_is_extended, rx_sid, rx_eid} <= ~{x, s, e};
  endtask
  // Code order: done, aborted, arb lost, bus error, queue sent, remote
  task automatic ev(input logic [3:0] f, input logic [5:0] k);
    @(posedge clk_sys);
    eng_fifo <= f;
    {eng_done, eng_aborted, eng_arb_lost, eng_bus_err, eng_queue_sent, eng_remote_rx} <= k;
    @(posedge clk_sys);
    {eng_done, eng_aborted, eng_arb_lost, eng_bus_err, eng_queue_sent, eng_remote_rx} <= 6'h0;
  endtask
endmodule

// ===== verif/cff_filter_fifo_cfg_tb_top.sv
// Self-checking bench for the filter and FIFO configuration block
`timescale 1ns/1ns
module cff_filter_fifo_cfg_tb_top
  import cff_pkg::*;
  ;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [7:0]       reg_addr = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic [2:0]       operating_mode_field = 3'h0;
  logic [3:0][28:0] acc_mask = '1;
  logic [31:0]      reg_rdata, fifo_addr;
  logic             rx_id_valid, rx_is_extended, match_hit, match_payload_only;
  logic [10:0]      rx_sid;
  logic [17:0]      rx_eid;
  logic [3:0]       match_fifo, match_filter, eng_fifo, fifo_ptr, tx_pick_fifo, abort_fifo;
  logic             eng_done, eng_aborted, eng_arb_lost, eng_bus_err, eng_queue_sent;
  logic             eng_remote_rx, tx_pick_valid, abort_req;
  logic [4:0]       fifo_depth;
  logic [15:0]      fifo_clear_pulse;
  int               fails = 0;
  int               n_checks = 0;
  int               cycles = 0;
  cff_filter_fifo_cfg i_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .operating_mode_field, .acc_mask, .rx_id_valid, .rx_is_extended, .rx_sid,
    .rx_eid, .match_hit, .match_fifo, .match_filter, .match_payload_only, .eng_fifo,
    .eng_done, .eng_aborted, .eng_arb_lost, .eng_bus_err, .eng_queue_sent, .eng_remote_rx,
    .fifo_addr, .fifo_ptr, .fifo_depth, .tx_pick_valid, .tx_pick_fifo, .abort_req,
    .abort_fifo, .fifo_clear_pulse);
  cff_engine_model i_eng (.clk_sys, .rx_id_valid, .rx_is_extended, .rx_sid, .rx_eid,
    .eng_fifo, .eng_done, .eng_aborted, .eng_arb_lost, .eng_bus_err, .eng_queue_sent,
    .eng_remote_rx);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fails++;
      stop_test;
    end
  end
  //////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    cmp(v, e);
  endtask
  task automatic set_mode(input logic [2:0] m);
    @(posedge clk_sys);
    operating_mode_field <= m;
  endtask
  // Hit, FIFO and filter packed as one value; a miss reads as zero
  task automatic hit(input logic x, input logic [10:0] s, input logic [17:0] e,
    input logic [8:0] exp);
    i_eng.frame(x, s, e);
    #1;
    cmp(match_hit ? {23'h0, match_hit, match_fifo, match_filter} : 32'h0, {23'h0, exp});
  endtask
  //////////////////////////////////////////////////
  task automatic t_reset;
    int i;
    rc(CFF_OFS_FLT_BANK, 32'h0);
    rc(CFF_OFS_BASE, 32'h0);
    for (i = 0; i < 16; i++)
      rc(CFF_OFS_FIFO + 8'(4 * i), 32'h0);
    rc(8'h08, 32'h0);
    cmp({27'h0, fifo_depth}, 32'h1);
    $display("t_reset done");
  endtask
  task automatic t_base;
    wr(CFF_OFS_BASE, 32'hffff_ffff);
    rc(CFF_OFS_BASE, 32'h0);
    set_mode(3'h4);
    wr(CFF_OFS_BASE, 32'h0000_1003);
    rc(CFF_OFS_BASE, 32'h0000_1000);
    wr(CFF_OFS_FIFO, 32'h0003_1000);
    rc(CFF_OFS_FIFO, 32'h0003_1000);
    i_eng.ev(4'h0, 6'h0);
    #1;
    cmp(fifo_addr, 32'h0000_1000);
    cmp({27'h0, fifo_depth}, 32'h4);
    i_eng.ev(4'h1, 6'h0);
    #1;
    cmp(fifo_addr, 32'h0000_1020);
    set_mode(3'h0);
    wr(CFF_OFS_FIFO, 32'h0);
    rc(CFF_OFS_FIFO, 32'h0003_1000);
    $display("t_base done");
  endtask
  task automatic t_match;
    logic [3:0][28:0] mk;
    logic [4:0] dl [3] = '{5'h00, 5'h0f, 5'h10};
    int m;
    wr(CFF_OFS_MATCH, {11'h123, 21'h0});
    wr(CFF_OFS_FLT_BANK, 32'h0000_0085);
    hit(1'b0, 11'h123, 18'h0, 9'h15c);
    hit(1'b0, 11'h122, 18'h0, 9'h0);
    hit(1'b1, 11'h123, 18'h0, 9'h0);
    for (m = 0; m < 4; m++)
    begin
      mk = '1;
      mk[m] = '0;
      @(posedge clk_sys);
      acc_mask <= mk;
      wr(CFF_OFS_FLT_BANK, 32'(8'h85 | (m << 5)));
      hit(1'b0, 11'h122, 18'h0, 9'h15c);
    end
    @(posedge clk_sys);
    acc_mask <= '1;
    for (m = 0; m < 3; m++)
    begin
      wr(CFF_OFS_FLT_BANK, {24'h0, 3'h4, dl[m]});
      hit(1'b0, 11'h123, 18'h0, dl[m][4] ? 9'h0 : {1'b1, dl[m][3:0], 4'hc});
      if (m == 0)
        cmp({31'h0, match_payload_only}, 32'h1);
    end
    wr(CFF_OFS_MATCH, 32'h0);
    rc(CFF_OFS_MATCH, {11'h123, 21'h0});
    wr(CFF_OFS_FLT_BANK, 32'h0000_0005);
    hit(1'b0, 11'h123, 18'h0, 9'h0);
    wr(CFF_OFS_MATCH + 8'h04, 32'hffff_ffff);
    rc(CFF_OFS_MATCH + 8'h04, 32'hffeb_ffff);
    wr(CFF_OFS_FLT_BANK, 32'h0000_8a00);
    hit(1'b1, 11'h7ff, 18'h3ffff, 9'h1ad);
    hit(1'b1, 11'h7ff, 18'h3fffe, 9'h0);
    hit(1'b0, 11'h7ff, 18'h3ffff, 9'h0);
    $display("t_match done");
  endtask
  task automatic t_fifo;
    logic [31:0] v;
    int i;
    set_mode(3'h4);
    // Send request only lands once the FIFO is already transmit
    wr(8'h88, 32'h0003_0083);
    wr(8'h8c, 32'h0000_0081);
    wr(8'h88, 32'h0003_008b);
    wr(8'h8c, 32'h0000_0089);
    i_eng.ev(4'h2, 6'h0);
    #1;
    cmp({27'h0, tx_pick_valid, tx_pick_fifo}, 32'h12);
    wr(8'h88, 32'h0003_0083);
    #1;
    cmp({27'h0, abort_req, abort_fifo}, 32'h12);
    i_eng.ev(4'h3, 6'h0);
    #1;
    cmp({27'h0, tx_pick_valid, tx_pick_fifo}, 32'h13);
    i_eng.ev(4'h3, 6'h02);
    rc(8'h8c, 32'h0000_0081);
    wr(8'h8c, 32'h0000_0085);
    i_eng.ev(4'h3, 6'h01);
    rc(8'h8c, 32'h0000_008d);
    wr(8'h90, 32'h0000_0008);
    rc(8'h90, 32'h0);
    i_eng.ev(4'h2, 6'h0);
    wr(8'h88, 32'h0003_2083);
    rc(8'h88, 32'h0003_0083);
    cmp({28'h0, fifo_ptr}, 32'h1);
    i_eng.ev(4'h2, 6'h0c);
    rc(8'h88, 32'h0003_00b3);
    rc(8'h88, 32'h0003_0083);
    i_eng.ev(4'h2, 6'h30);
    rc(8'h88, 32'h0003_00c3);
    i_eng.ev(4'h2, 6'h20);
    rc(8'h88, 32'h0003_0083);
    i_eng.ev(4'h2, 6'h30);
    i_eng.ev(4'h2, 6'h08);
    // Clear and advance together: the clear must win
    wr(8'h88, 32'h0003_6083);
    #1;
    cmp({16'h0, fifo_clear_pulse}, 32'h4);
    v = 32'hffff_ffff;
    for (i = 0; i < 8 && v[14] !== 1'b0; i++)
      rd(8'h88, v);
    cmp(v, 32'h0003_0083);
    cmp({28'h0, fifo_ptr}, 32'h0);
    i_eng.ev(4'h0, 6'h0);
    wr(8'h80, 32'h0003_3000);
    wr(8'h80, 32'h0003_3000);
    rc(8'h80, 32'h0003_1000);
    cmp({28'h0, fifo_ptr}, 32'h2);
    $display("t_fifo done");
  endtask
  //////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_base;
    t_match;
    t_fifo;
    stop_test;
  end
endmodule
